// ==== inc/fep_pkg.sv ====
// Package: constants for the fast EEPROM PROM-replacement port controller
package fep_pkg;
	localparam int          ADDR_W_SMALL  = 11;
	localparam int          ADDR_W_LARGE  = 12;
	localparam int          DATA_W        = 8;
	localparam int          COL_W         = 4;
	localparam int          CLK_MHZ       = 250;
	localparam int          CLK_PERIOD_PS = 4000;
	localparam int          PULSE_MS      = 5;
	localparam int          PULSE_CYCLES  = PULSE_MS * 1000 * CLK_MHZ;
	localparam int          SETTLE_NS     = 20;
	localparam int          SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          RECOVER_NS    = 10000;
	localparam int          RECOVER_CYCLES = (RECOVER_NS * 1000) / CLK_PERIOD_PS;
	localparam int          ACCESS_NS     = 60;
	localparam int          ACCESS_CYCLES = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [2:0]
	{
		FEP_IDLE   = 3'b000,
		FEP_SETUP  = 3'b001,
		FEP_ACCESS = 3'b011,
		FEP_PULSE  = 3'b010,
		FEP_HOLD   = 3'b110,
		FEP_DONE   = 3'b111
	} fep_state_t;
endpackage

// ==== inc/fep_timer_if.sv ====
// Interface: load and expiry between controller and its cycle timer
`timescale 1ns/1ps
`default_nettype none
interface fep_timer_if #(parameter int CNT_W = 21);
	logic             load;
	logic [CNT_W-1:0] count;
	logic             expired;
	modport ctrl  (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface
`default_nettype wire

// ==== verilog/fep_timer.sv ====
// Down-counting cycle timer for phase lengths
`timescale 1ns/1ps
`default_nettype none
module fep_timer #(parameter int CNT_W = 21)
(
	input  wire logic     ref_clk,
	input  wire logic     rst,
	fep_timer_if.timer    tmr
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	assign cnt_next    = tmr.load ? tmr.count :
	                     (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
	// Load kept out of expiry, or the sequencer would loop on itself
	assign tmr.expired = (cnt_reg == '0);
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
endmodule // fep_timer
`default_nettype wire

// ==== verilog/fep_host.sv ====
// Host-side controller driving the fast EEPROM PROM-replacement port
//
// Operation
// - A read places the wanted address on the address pins before any output enable.
// - Selects move to read levels only after the address has settled.
// - During a write pulse address, data and a low secondary select are held steady.
// - The high-voltage level is applied on its own pin, primary select held high, as one pulse of 5 ms per byte.
`timescale 1ns/1ps
`default_nettype none
module fep_host #(
	parameter int LARGE        = 0,
	parameter int PULSE_CYCLES = fep_pkg::PULSE_CYCLES
)
(
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst,
	input  wire logic                                 req_valid,
	input  wire logic                                 req_write,
	input  wire logic [fep_pkg::ADDR_W_LARGE-1:0]     req_addr,
	input  wire logic [fep_pkg::DATA_W-1:0]           req_wdata,
	output logic                                      req_ready,
	output logic                                      rsp_valid,
	output logic      [fep_pkg::DATA_W-1:0]           rsp_rdata,
	output logic      [fep_pkg::ADDR_W_SMALL-1:0]     mem_addr,
	output logic                                      primary_select_n,
	output logic                                      programming_high_voltage,
	output logic                                      secondary_select,
	output logic                                      tertiary_select_or_top_address_bit,
	input  wire logic [fep_pkg::DATA_W-1:0]           mem_data_in,
	output logic      [fep_pkg::DATA_W-1:0]           mem_data_out,
	output logic                                      mem_data_oe_n
);
	localparam int CNT_W = 32;
	if (LARGE != 0 && LARGE != 1)
	begin : g_chk_large
		$error("LARGE must be 0 or 1");
	end
	if (PULSE_CYCLES < 1)
	begin : g_chk_pulse
		$error("PULSE_CYCLES must be at least 1");
	end

	// ------------------------------------------------------------
	// Timer
	// ------------------------------------------------------------
	fep_timer_if #(.CNT_W(CNT_W)) tmr ();
	fep_timer #(.CNT_W(CNT_W)) u_timer
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.tmr     (tmr)
	);

	// ------------------------------------------------------------
	// State and registers
	// ------------------------------------------------------------
	fep_pkg::fep_state_t                   state_reg;
	fep_pkg::fep_state_t                   state_next;
	logic                                  write_reg;
	logic [fep_pkg::ADDR_W_LARGE-1:0]      addr_reg;
	logic [fep_pkg::DATA_W-1:0]            wdata_reg;
	logic [fep_pkg::DATA_W-1:0]            rdata_reg;
	logic                                  rsp_reg;
	logic [fep_pkg::DATA_W-1:0]            sync1_reg;
	logic [fep_pkg::DATA_W-1:0]            sync2_reg;
	logic                                  hv_reg;

	wire take    = req_valid && (state_reg == fep_pkg::FEP_IDLE);
	wire t_exp   = tmr.expired;
	wire in_read = (state_reg == fep_pkg::FEP_ACCESS) && !write_reg;
	wire in_pulse = (state_reg == fep_pkg::FEP_PULSE);
	wire in_wr   = write_reg && (state_reg == fep_pkg::FEP_SETUP || in_pulse
	               || state_reg == fep_pkg::FEP_HOLD);

	assign req_ready = (state_reg == fep_pkg::FEP_IDLE);

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		tmr.load   = 1'b0;
		tmr.count  = '0;
		case (state_reg)
			fep_pkg::FEP_IDLE:
				if (take)
				begin
					// Address first, selects later
					state_next = fep_pkg::FEP_SETUP;
					tmr.load   = 1'b1;
					tmr.count  = CNT_W'(fep_pkg::SETTLE_CYCLES - 1);
				end
			fep_pkg::FEP_SETUP:
				if (t_exp)
				begin
					tmr.load = 1'b1;
					if (write_reg)
					begin
						// Single pulse, no erase first
						state_next = fep_pkg::FEP_PULSE;
						tmr.count  = CNT_W'(PULSE_CYCLES - 1);
					end
					else
					begin
						state_next = fep_pkg::FEP_ACCESS;
						tmr.count  = CNT_W'(fep_pkg::ACCESS_CYCLES + 1);
					end
				end
			fep_pkg::FEP_ACCESS:
				if (t_exp)
					state_next = fep_pkg::FEP_DONE;
			fep_pkg::FEP_PULSE:
				if (t_exp)
				begin
					state_next = fep_pkg::FEP_HOLD;
					tmr.load   = 1'b1;
					tmr.count  = CNT_W'(fep_pkg::RECOVER_CYCLES - 1);
				end
			fep_pkg::FEP_HOLD:
				if (t_exp)
					state_next = fep_pkg::FEP_DONE;
			fep_pkg::FEP_DONE:
				state_next = fep_pkg::FEP_IDLE;
			default:
				state_next = fep_pkg::FEP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_reg <= fep_pkg::FEP_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			write_reg <= 1'b0;
			addr_reg  <= '0;
			wdata_reg <= '0;
		end
		else if (take)
		begin
			// Held for the whole pulse
			write_reg <= req_write;
			addr_reg  <= req_addr;
			wdata_reg <= req_wdata;
		end
	end

	// Pin data passes two flops before use
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= mem_data_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Last access sample is what the device drove
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_reg <= '0;
			rsp_reg   <= 1'b0;
		end
		else
		begin
			if (in_read && t_exp)
				rdata_reg <= sync2_reg;
			rsp_reg <= (state_reg == fep_pkg::FEP_DONE) && !write_reg;
		end
	end
	assign rsp_valid = rsp_reg;
	assign rsp_rdata = rdata_reg;

	// Registered so a state decode glitch never reaches the high-voltage pin
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			hv_reg <= 1'b0;
		else
			hv_reg <= in_pulse && write_reg;
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	// Bits 0..3 column, rest row; top bit shared with third select
	wire top_bit = addr_reg[fep_pkg::ADDR_W_LARGE-1];
	assign mem_addr = addr_reg[fep_pkg::ADDR_W_SMALL-1:0];
	assign tertiary_select_or_top_address_bit = (LARGE != 0) ? top_bit : in_read;
	// Read: primary low, secondary high, third select high when small; write: high voltage, secondary low
	assign primary_select_n         = !in_read;
	assign programming_high_voltage = hv_reg;
	assign secondary_select         = in_read;
	// Drive data only in write mode
	assign mem_data_out  = wdata_reg;
	assign mem_data_oe_n = !in_wr;
endmodule // fep_host
`default_nettype wire

// ==== verif/fep_host_sva.sv ====
// Checker: port assertions for the host controller
`timescale 1ns/1ps
`default_nettype none
module fep_host_sva #(parameter int PULSE_CYCLES = 50, parameter int LARGE = 0)
(
	input wire logic	ref_clk,
	input wire logic	rst,
	input wire logic [10:0]	mem_addr,
	input wire logic	primary_select_n,
	input wire logic	programming_high_voltage,
	input wire logic	secondary_select,
	input wire logic	tertiary_select_or_top_address_bit,
	input wire logic [7:0]	mem_data_out,
	input wire logic	mem_data_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int	pcnt_reg;
	// Counter, as the pulse is far too long to unroll
	always_ff @(posedge ref_clk or posedge rst)
		if (rst) pcnt_reg <= 0;
		else pcnt_reg <= programming_high_voltage ? pcnt_reg + 1 : 0;
	addr_settle_a:
		assert property ($fell(primary_select_n) |-> mem_addr == $past(mem_addr, 3))
		else $error("address not settled before select");
	read_addr_a:
		assert property (!primary_select_n |-> $stable(mem_addr)) else $error("address moved in read");
	read_levels_a:
		assert property (!primary_select_n |-> secondary_select
			&& (LARGE != 0 || tertiary_select_or_top_address_bit) && !programming_high_voltage)
		else $error("read select levels wrong");
	pulse_hold_a:
		assert property (programming_high_voltage |-> !secondary_select && !mem_data_oe_n
			&& $stable(mem_addr) && $stable(mem_data_out)
			&& $stable(tertiary_select_or_top_address_bit)) else $error("pulse hold broken");
	post_hold_a:
		assert property ($fell(programming_high_voltage) |-> !mem_data_oe_n && $stable(mem_addr))
		else $error("data dropped at pulse end");
	pulse_len_a:
		assert property ($fell(programming_high_voltage) |-> pcnt_reg == PULSE_CYCLES)
		else $error("pulse length wrong");
	pulse_bound_a:
		assert property (pcnt_reg <= PULSE_CYCLES) else $error("pulse too long");
	no_fight_a:
		assert property (!mem_data_oe_n |-> primary_select_n) else $error("bus driven in read");
endmodule // fep_host_sva
bind fep_host fep_host_sva #(.PULSE_CYCLES(PULSE_CYCLES), .LARGE(LARGE)) u_sva (.ref_clk, .rst,
	.mem_addr, .primary_select_n, .programming_high_voltage, .secondary_select,
	.tertiary_select_or_top_address_bit, .mem_data_out, .mem_data_oe_n);
`default_nettype wire

// ==== verif/fep_dev_model.sv ====
// Behavioural model of the small or large EEPROM device
`timescale 1ns/1ps
`default_nettype none
module fep_dev_model #(parameter int LARGE = 0)
(
	input wire logic [10:0]	addr,
	input wire logic	primary_select_n,
	input wire logic	programming_high_voltage,
	input wire logic	secondary_select,
	input wire logic	tertiary_select,
	input wire logic [7:0]	din,
	output logic [7:0]	dout,
	output int	pulses
);
	logic [7:0]	mem [0:4095];
	logic [7:0]	last;
	logic	hv_was;
	// Large part takes the shared pin as top address bit
	wire [11:0]	idx = {(LARGE != 0) && tertiary_select, addr};
	wire	rd = !primary_select_n && secondary_select
		&& (LARGE != 0 || tertiary_select);
	initial
	begin
		pulses = 0;
		last = 8'h00;
		hv_was = 1'b0;
		for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h3c;
	end
	// Byte taken at a true 1 to 0 pulse end, cleared first
	always @(programming_high_voltage)
	begin
		if (hv_was === 1'b1 && programming_high_voltage === 1'b0 && secondary_select === 1'b0)
		begin
			mem[idx] = 8'hff;
			mem[idx] = mem[idx] & din;
			pulses++;
		end
		hv_was = programming_high_voltage;
	end
	// Released pins show the inverse, never a stale byte
	always @* if (rd) last = mem[idx];
	assign dout = rd ? mem[idx] : ~last;
endmodule // fep_dev_model
`default_nettype wire

// ==== verif/fep_host_tb.sv ====
// Testbench for the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module fep_host_tb;
	logic	ref_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid;
	logic	ps_n, hv, ss, ts, oe_n;
	logic [11:0]	req_addr = 12'h000;
	logic [10:0]	mem_addr;
	logic [7:0]	req_wdata = 8'h00, rsp_rdata, dout, dev_q, q;
	int	fail_count = 0, checks = 0, pulses;
	wire [7:0]	bus = !oe_n ? dout : dev_q;
	logic	ps2_n, hv2, ss2, ts2, oe2_n, ready2, valid2;
	logic [10:0]	mem_addr2;
	logic [7:0]	rsp_rdata2, dout2, dev_q2, q2;
	int	pulses2;
	wire [7:0]	bus2 = !oe2_n ? dout2 : dev_q2;
	fep_host #(.LARGE(0), .PULSE_CYCLES(50)) u_dut (.ref_clk, .rst, .req_valid, .req_write,
		.req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
		.primary_select_n(ps_n), .programming_high_voltage(hv), .secondary_select(ss),
		.tertiary_select_or_top_address_bit(ts), .mem_data_in(bus), .mem_data_out(dout),
		.mem_data_oe_n(oe_n));
	fep_dev_model u_dev (.addr(mem_addr), .primary_select_n(ps_n), .programming_high_voltage(hv),
		.secondary_select(ss), .tertiary_select(ts), .din(bus), .dout(dev_q), .pulses);
	// Large organisation runs in lockstep on the same requests
	fep_host #(.LARGE(1), .PULSE_CYCLES(50)) u_dut_large (.ref_clk, .rst, .req_valid,
		.req_write, .req_addr, .req_wdata, .req_ready(ready2), .rsp_valid(valid2),
		.rsp_rdata(rsp_rdata2), .mem_addr(mem_addr2), .primary_select_n(ps2_n),
		.programming_high_voltage(hv2), .secondary_select(ss2),
		.tertiary_select_or_top_address_bit(ts2), .mem_data_in(bus2), .mem_data_out(dout2),
		.mem_data_oe_n(oe2_n));
	fep_dev_model #(.LARGE(1)) u_dev_large (.addr(mem_addr2), .primary_select_n(ps2_n),
		.programming_high_voltage(hv2), .secondary_select(ss2), .tertiary_select(ts2),
		.din(bus2), .dout(dev_q2), .pulses(pulses2));
	initial forever #2 ref_clk = ~ref_clk;
	task automatic op(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		do @(negedge ref_clk);
		while (!(w ? req_ready === 1'b1 : rsp_valid === 1'b1) && ++n < 4000);
		q = rsp_rdata;
		q2 = rsp_rdata2;
		`CHK(n < 4000, 1'b1)
		`CHK({ready2, valid2}, {req_ready, rsp_valid})
	endtask
	task automatic t_wr_rd;
		op(1'b1, 12'h0f3, 8'h5a);
		`CHK(pulses, 1)
		op(1'b0, 12'h0f3, 8'h00);
		`CHK(q, 8'h5a)
		op(1'b1, 12'h0f3, 8'ha5);
		op(1'b0, 12'h0f3, 8'h00);
		`CHK(q, 8'ha5)
		`CHK(pulses, 2)
		$display("test wr_rd done");
	endtask
	task automatic t_edges;
		op(1'b0, 12'h123, 8'h00);
		`CHK(q, 8'h1f)
		op(1'b1, 12'h7ff, 8'h81);
		op(1'b1, 12'h000, 8'h7e);
		op(1'b0, 12'h7ff, 8'h00);
		`CHK(q, 8'h81)
		op(1'b0, 12'h000, 8'h00);
		`CHK(q, 8'h7e)
		$display("test edges done");
	endtask
	task automatic t_large;
		op(1'b1, 12'h8f3, 8'hc3);
		`CHK(pulses2, 5)
		op(1'b0, 12'h8f3, 8'h00);
		`CHK(q2, 8'hc3)
		`CHK(q, 8'hc3)
		op(1'b0, 12'h0f3, 8'h00);
		`CHK(q2, 8'ha5)
		op(1'b0, 12'hfff, 8'h00);
		`CHK(q2, 8'hc3)
		`CHK(q, 8'h81)
		$display("test large done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#160000;
		fail_count++;
		give_verdict();
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_wr_rd();
		t_edges();
		t_large();
		give_verdict();
	end
endmodule // fep_host_tb
`default_nettype wire
